/* File: core/pdr_responder.v */
// Peer-delay responder with timestamp counter, pin and egress stamps
// Function
// R1: Build and send peer-delay response in hardware
// R2: Accept zero, one or two VLAN tags
// R3: Software originates requests, handles responses
// R4: Latch local time when request arrives
// R5: Zero the request receipt timestamp field
// R6: Add residence time to correction field
// R7: One-step: updated correction goes in response
// R8: Requester computes mean path delay itself
// R9: Each end both requests and responds
// R10: Answer locally, never forward over stacking
// R11: Timestamp every ingress packet, classify PTP
// R12: Recompute frame check sequence on egress
// R13: Correction adjusted in hardware, short residence
// R14: Two-step: per-port egress timestamp FIFO
// R15: PTP packets optionally trapped to host
// R16: One/two-step, end-to-end and peer modes
// R17: Timestamp counter adjustable for phase lock
// R18: Three sync pins with edge timestamps
// R19: Response leaves on the request's port
`timescale 1ns/1ps
`include "pdr_consts.vh"
module pdr_responder #(
	parameter [47:0] OWN_MAC = 48'h020000000001,
	// Arbitrary value
	parameter [63:0] CLOCK_ID = 64'h0200000000000001
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Mode controls
	input wire one_step,
	input wire p2p_mode,
	input wire trap_en,
	input wire [`PDR_NPORT-1:0] stack_mask,
	// Timestamp counter control
	input wire ts_load,
	input wire [`PDR_TS_W-1:0] ts_load_val,
	input wire ts_adj,
	input wire [31:0] ts_adj_delta,
	output wire [`PDR_TS_W-1:0] ts_now,
	// Ingress byte stream, FCS included
	input wire rx_valid,
	input wire rx_sop,
	input wire rx_eop,
	input wire [7:0] rx_data,
	input wire [`PDR_PORT_W-1:0] rx_port,
	// Ingress classification
	output reg ing_ts_valid,
	output reg [`PDR_TS_W-1:0] ing_ts,
	output reg ing_ptp,
	output reg host_trap,
	output reg fwd_block,
	output reg req_drop,
	// Response byte stream
	input wire tx_ready,
	output reg tx_valid,
	output reg tx_sop,
	output reg tx_eop,
	output reg [7:0] tx_data,
	output reg [`PDR_PORT_W-1:0] tx_port,
	// Switch egress of PTP frames
	input wire eg_sop,
	input wire eg_ptp,
	input wire [`PDR_PORT_W-1:0] eg_port,
	// Per-port egress timestamp FIFOs
	input wire [`PDR_NPORT-1:0] efifo_pop,
	output wire [`PDR_NPORT*`PDR_TS_W-1:0] efifo_ts,
	output wire [`PDR_NPORT-1:0] efifo_empty,
	output wire [`PDR_NPORT-1:0] efifo_full,
	// Time sync pins
	input wire [`PDR_NPIN-1:0] time_sync_pins,
	output wire [`PDR_NPIN-1:0] pin_evt,
	output wire [`PDR_NPIN*`PDR_TS_W-1:0] pin_ts
);
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_SEND = 2'b01;
	localparam [1:0] ST_FCS = 2'b10;

	reg [`PDR_TS_W-1:0] ts_r;
	reg [7:0] mem [0:`PDR_BUF_DEPTH-1];
	reg [`PDR_IDX_W-1:0] rx_idx_r;
	reg [`PDR_IDX_W-1:0] etype_pos_r;
	reg [`PDR_IDX_W-1:0] base_r;
	reg [1:0] tags_r;
	reg is_ptp_r;
	reg [3:0] msg_r;
	reg [7:0] prev_r;
	reg [63:0] corr_r;
	reg [`PDR_TS_W-1:0] t2_r;
	reg [`PDR_PORT_W-1:0] rport_r;
	reg [1:0] state_r;
	reg [`PDR_IDX_W-1:0] tx_idx_r;
	reg [`PDR_IDX_W-1:0] tx_len_r;
	reg [`PDR_IDX_W-1:0] tx_base_r;
	reg [63:0] corr_new_r;
	reg [31:0] crc_r;
	reg [1:0] fcs_cnt_r;
	reg rx_clean_r;
	reg [7:0] nb;
	wire [`PDR_IDX_W-1:0] req_src;
	wire [`PDR_IDX_W-1:0] cur_idx;
	wire [`PDR_IDX_W-1:0] ofs;
	wire [15:0] cur_type;
	wire [31:0] crc_nxt;
	wire [`PDR_TS_W-1:0] resid;
	wire load;
	wire req_ok;
	wire busy;
	wire [2:0] mac_sel;
	wire [2:0] corr_sel;
	wire [2:0] id_sel;

	assign ts_now = ts_r;
	assign cur_idx = rx_sop ? {`PDR_IDX_W{1'b0}} : rx_idx_r;
	assign cur_type = {prev_r, rx_data};
	assign busy = (state_r != ST_IDLE);
	assign load = (!tx_valid || tx_ready);
	assign resid = ts_r - t2_r;
	assign ofs = tx_idx_r - tx_base_r;
	assign req_src = tx_idx_r - `PDR_REQID_SHIFT;
	assign mac_sel = 3'h5 - tx_idx_r[2:0] + 3'h6;
	assign corr_sel = 3'h7 - ofs[2:0];
	assign id_sel = 3'h7 - ofs[2:0] + 3'h4;

	// Counter free runs, a load or a step keeps it phase locked
	always @(posedge sys_clk) begin
		if (rst)
			ts_r <= {`PDR_TS_W{1'b0}};
		else if (ts_load)
			ts_r <= ts_load_val; // [R17]
		else if (ts_adj)
			ts_r <= ts_r + `PDR_TS_INC_NS + {{(`PDR_TS_W-32){ts_adj_delta[31]}},
				ts_adj_delta}; // [R17]
		else
			ts_r <= ts_r + `PDR_TS_INC_NS;
	end

	// A request needs whole PTP body plus FCS inside the buffer
	assign req_ok = is_ptp_r && (msg_r == `PDR_MSG_PDREQ) && p2p_mode &&
		!stack_mask[rport_r] && // [R10]
		(cur_idx + 1'b1 >= base_r + `PDR_PTP_LEN + `PDR_FCS_LEN) &&
		(cur_idx < `PDR_BUF_DEPTH);

	// Ingress parse and store
	always @(posedge sys_clk) begin
		if (rst) begin
			rx_idx_r <= {`PDR_IDX_W{1'b0}};
			etype_pos_r <= `PDR_ETYPE_OFS;
			base_r <= {`PDR_IDX_W{1'b0}};
			tags_r <= 2'b00;
			is_ptp_r <= 1'b0;
			msg_r <= 4'h0;
			prev_r <= 8'h00;
			corr_r <= 64'h0;
			t2_r <= {`PDR_TS_W{1'b0}};
			rport_r <= {`PDR_PORT_W{1'b0}};
			rx_clean_r <= 1'b0;
			ing_ts_valid <= 1'b0;
			ing_ts <= {`PDR_TS_W{1'b0}};
			ing_ptp <= 1'b0;
			host_trap <= 1'b0;
			fwd_block <= 1'b0;
			req_drop <= 1'b0;
		end else begin
			ing_ts_valid <= 1'b0;
			ing_ptp <= 1'b0;
			host_trap <= 1'b0;
			fwd_block <= 1'b0;
			req_drop <= 1'b0;
			if (rx_valid) begin
				prev_r <= rx_data;
				rx_idx_r <= (cur_idx == {`PDR_IDX_W{1'b1}}) ? cur_idx : cur_idx + 1'b1;
				// Buffer frozen while a response reads it
				if (cur_idx < `PDR_BUF_DEPTH && !busy)
					mem[cur_idx[6:0]] <= rx_data;
				if (rx_sop) begin
					rx_clean_r <= 1'b1;
					t2_r <= ts_r; // [R4]
					rport_r <= rx_port;
					ing_ts_valid <= 1'b1; // [R11]
					ing_ts <= ts_r; // [R11]
					etype_pos_r <= `PDR_ETYPE_OFS;
					tags_r <= 2'b00;
					is_ptp_r <= 1'b0;
				end else if (cur_idx == etype_pos_r + 1'b1) begin
					if ((cur_type == `PDR_VLAN_C || cur_type == `PDR_VLAN_S) &&
						tags_r != 2'b10) begin
						tags_r <= tags_r + 1'b1; // [R2]
						etype_pos_r <= etype_pos_r + 8'h04; // [R2]
					end else if (cur_type == `PDR_ETYPE_PTP) begin
						is_ptp_r <= 1'b1; // [R11]
						base_r <= cur_idx + 1'b1;
					end
				end
				if (busy)
					rx_clean_r <= 1'b0;
				if (is_ptp_r && cur_idx == base_r)
					msg_r <= rx_data[3:0];
				if (is_ptp_r && cur_idx >= base_r + `PDR_OFS_CORR_FIRST &&
					cur_idx <= base_r + `PDR_OFS_CORR_LAST)
					corr_r <= {corr_r[55:0], rx_data};
				if (rx_eop && !rx_sop) begin
					ing_ptp <= is_ptp_r; // [R11]
					host_trap <= is_ptp_r && trap_en; // [R15]
					// Request is consumed here, never forwarded
					fwd_block <= is_ptp_r && (msg_r == `PDR_MSG_PDREQ); // [R10]
					// One response in flight; a second request is dropped
					req_drop <= req_ok && (busy || !rx_clean_r);
				end
			end
		end
	end

	// Response byte: copy of request with fields rewritten
	always @* begin
		nb = mem[tx_idx_r[6:0]];
		if (tx_idx_r >= `PDR_SA_FIRST && tx_idx_r <= `PDR_SA_LAST)
			nb = OWN_MAC[{mac_sel, 3'b000} +: 8];
		if (ofs == 8'h00)
			nb = {mem[tx_idx_r[6:0]][7:4], `PDR_MSG_PDRESP}; // [R1]
		else if (ofs >= `PDR_OFS_CORR_FIRST && ofs <= `PDR_OFS_CORR_LAST)
			nb = corr_new_r[{corr_sel, 3'b000} +: 8]; // [R7]
		else if (ofs >= `PDR_OFS_SRC_FIRST && ofs <= `PDR_OFS_SRC_LAST)
			nb = CLOCK_ID[{id_sel, 3'b000} +: 8];
		else if (ofs == `PDR_OFS_SRC_PHI)
			nb = 8'h00;
		else if (ofs == `PDR_OFS_SRC_PLO)
			nb = {{(8-`PDR_PORT_W){1'b0}}, tx_port} + 8'h01;
		else if (ofs >= `PDR_OFS_RRTS_FIRST && ofs <= `PDR_OFS_RRTS_LAST)
			nb = 8'h00; // [R5]
		else if (ofs >= `PDR_OFS_REQID_FIRST && ofs <= `PDR_OFS_REQID_LAST)
			nb = mem[req_src[6:0]];
	end

	pdr_crc32 u_crc (
		.crc_in(crc_r),
		.data_in(nb),
		.crc_out(crc_nxt)
	);

	// Response transmit
	always @(posedge sys_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			tx_idx_r <= {`PDR_IDX_W{1'b0}};
			tx_len_r <= {`PDR_IDX_W{1'b0}};
			tx_base_r <= {`PDR_IDX_W{1'b0}};
			corr_new_r <= 64'h0;
			crc_r <= `PDR_CRC_INIT;
			fcs_cnt_r <= 2'b00;
			tx_valid <= 1'b0;
			tx_sop <= 1'b0;
			tx_eop <= 1'b0;
			tx_data <= 8'h00;
			tx_port <= {`PDR_PORT_W{1'b0}};
		end else begin
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				// Start straight after eop keeps residence short
				if (rx_valid && rx_eop && !rx_sop && req_ok && rx_clean_r) begin
					state_r <= ST_SEND; // [R1]
					tx_idx_r <= {`PDR_IDX_W{1'b0}};
					tx_len_r <= cur_idx + 1'b1 - `PDR_FCS_LEN;
					tx_base_r <= base_r;
					tx_port <= rport_r; // [R19]
					crc_r <= `PDR_CRC_INIT;
					// Two-step leaves correction untouched
					if (one_step)
						corr_new_r <= corr_r + {resid, 16'h0000}; // [R6] [R13] [R16]
					else
						corr_new_r <= corr_r; // [R16]
				end
			end
			ST_SEND: begin
				if (load) begin
					tx_valid <= 1'b1;
					tx_sop <= (tx_idx_r == {`PDR_IDX_W{1'b0}});
					tx_eop <= 1'b0;
					tx_data <= nb;
					crc_r <= crc_nxt; // [R12]
					tx_idx_r <= tx_idx_r + 1'b1;
					if (tx_idx_r + 1'b1 == tx_len_r) begin
						state_r <= ST_FCS;
						fcs_cnt_r <= 2'b00;
					end
				end
			end
			ST_FCS: begin
				if (load) begin
					tx_valid <= 1'b1;
					tx_sop <= 1'b0;
					tx_data <= ~crc_r[{fcs_cnt_r, 3'b000} +: 8]; // [R12]
					tx_eop <= (fcs_cnt_r == 2'b11);
					fcs_cnt_r <= fcs_cnt_r + 1'b1;
					if (fcs_cnt_r == 2'b11)
						state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Two-step stamps: switch egress PTP frames and own responses
	genvar p;
	generate
		for (p = 0; p < `PDR_NPORT; p = p + 1) begin : g_port
			wire push_p;
			assign push_p = !one_step && ((eg_sop && eg_ptp && eg_port == p) ||
				(tx_valid && tx_ready && tx_sop && tx_port == p)); // [R14]
			pdr_tsfifo u_fifo (
				.sys_clk(sys_clk),
				.rst(rst),
				.push(push_p),
				.din(ts_r),
				.pop(efifo_pop[p]),
				.dout(efifo_ts[p*`PDR_TS_W +: `PDR_TS_W]),
				.empty(efifo_empty[p]),
				.full(efifo_full[p])
			);
		end
	endgenerate

	// Sync pins: rising edge captures the counter
	genvar k;
	generate
		for (k = 0; k < `PDR_NPIN; k = k + 1) begin : g_pin
			reg [`PDR_TS_W-1:0] cap_r;
			reg last_r;
			reg evt_r;
			assign pin_ts[k*`PDR_TS_W +: `PDR_TS_W] = cap_r;
			assign pin_evt[k] = evt_r;
			always @(posedge sys_clk) begin
				if (rst) begin
					cap_r <= {`PDR_TS_W{1'b0}};
					last_r <= 1'b0;
					evt_r <= 1'b0;
				end else begin
					last_r <= time_sync_pins[k];
					evt_r <= time_sync_pins[k] && !last_r; // [R18]
					if (time_sync_pins[k] && !last_r)
						cap_r <= ts_r; // [R18]
				end
			end
		end
	endgenerate
endmodule // pdr_responder

/* File: core/pdr_consts.vh */
// Constants for the peer-delay responder and timestamp unit
`ifndef PDR_CONSTS_VH
`define PDR_CONSTS_VH
`define PDR_NPORT 4
`define PDR_PORT_W 2
`define PDR_NPIN 3
`define PDR_TS_W 48
`define PDR_CLK_PERIOD_NS 10
`define PDR_TS_INC_NS `PDR_CLK_PERIOD_NS
`define PDR_BUF_DEPTH 128
`define PDR_IDX_W 8
`define PDR_FIFO_DEPTH 8
`define PDR_FIFO_AW 3
`define PDR_ETYPE_OFS 8'h0C
`define PDR_SA_FIRST 8'h06
`define PDR_SA_LAST 8'h0B
`define PDR_VLAN_C 16'h8100
`define PDR_VLAN_S 16'h88A8
`define PDR_ETYPE_PTP 16'h88F7
`define PDR_MSG_PDREQ 4'h2
`define PDR_MSG_PDRESP 4'h3
`define PDR_PTP_LEN 8'h36
`define PDR_FCS_LEN 8'h04
`define PDR_OFS_CORR_FIRST 8'h08
`define PDR_OFS_CORR_LAST 8'h0F
`define PDR_OFS_SRC_FIRST 8'h14
`define PDR_OFS_SRC_LAST 8'h1B
`define PDR_OFS_SRC_PHI 8'h1C
`define PDR_OFS_SRC_PLO 8'h1D
`define PDR_OFS_RRTS_FIRST 8'h22
`define PDR_OFS_RRTS_LAST 8'h2B
`define PDR_OFS_REQID_FIRST 8'h2C
`define PDR_OFS_REQID_LAST 8'h35
`define PDR_REQID_SHIFT 8'h18
`define PDR_CRC_INIT 32'hFFFFFFFF
`define PDR_CRC_POLY 32'hEDB88320
`endif

/* File: core/pdr_crc32.v */
// Ethernet frame check sequence, one byte per step
`timescale 1ns/1ps
`include "pdr_consts.vh"
module pdr_crc32 (
	// Running value
	input wire [31:0] crc_in,
	// Byte to fold in
	input wire [7:0] data_in,
	// Updated value
	output reg [31:0] crc_out
);
	integer i;
	always @* begin
		crc_out = crc_in ^ {24'h000000, data_in};
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_out[0])
				crc_out = (crc_out >> 1) ^ `PDR_CRC_POLY;
			else
				crc_out = crc_out >> 1;
		end
	end
endmodule // pdr_crc32

/* File: core/pdr_tsfifo.v */
// Small timestamp FIFO for one egress port
`timescale 1ns/1ps
`include "pdr_consts.vh"
module pdr_tsfifo (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Write side
	input wire push,
	input wire [`PDR_TS_W-1:0] din,
	// Read side
	input wire pop,
	output wire [`PDR_TS_W-1:0] dout,
	output wire empty,
	output wire full
);
	reg [`PDR_TS_W-1:0] mem [0:`PDR_FIFO_DEPTH-1];
	reg [`PDR_FIFO_AW:0] wr_r;
	reg [`PDR_FIFO_AW:0] rd_r;
	assign empty = (wr_r == rd_r);
	assign full = (wr_r[`PDR_FIFO_AW] != rd_r[`PDR_FIFO_AW]) &&
		(wr_r[`PDR_FIFO_AW-1:0] == rd_r[`PDR_FIFO_AW-1:0]);
	assign dout = mem[rd_r[`PDR_FIFO_AW-1:0]];
	// Push while full is dropped, oldest stamps are kept
	always @(posedge sys_clk) begin
		if (rst) begin
			wr_r <= {(`PDR_FIFO_AW+1){1'b0}};
			rd_r <= {(`PDR_FIFO_AW+1){1'b0}};
		end else begin
			if (push && !full) begin
				mem[wr_r[`PDR_FIFO_AW-1:0]] <= din;
				wr_r <= wr_r + 1'b1;
			end
			if (pop && !empty)
				rd_r <= rd_r + 1'b1;
		end
	end
endmodule // pdr_tsfifo

/* File: test/pdr_checker.sv */
// Port-level assertions for the peer-delay responder
`timescale 1ns/1ps
`include "pdr_consts.vh"
module pdr_checker (
	// Clock, reset, controls
	input wire sys_clk,
	input wire rst,
	input wire trap_en,
	input wire ts_load,
	input wire ts_adj,
	input wire [`PDR_TS_W-1:0] ts_load_val,
	input wire [`PDR_TS_W-1:0] ts_now,
	// Ingress side
	input wire rx_valid,
	input wire rx_sop,
	input wire ing_ts_valid,
	input wire [`PDR_TS_W-1:0] ing_ts,
	input wire ing_ptp,
	input wire host_trap,
	input wire fwd_block,
	// Response side
	input wire tx_ready,
	input wire tx_valid,
	input wire tx_sop,
	input wire tx_eop,
	input wire [7:0] tx_data,
	input wire [`PDR_PORT_W-1:0] tx_port,
	// Sync pins
	input wire [`PDR_NPIN-1:0] time_sync_pins,
	input wire [`PDR_NPIN-1:0] pin_evt,
	input wire [`PDR_NPIN*`PDR_TS_W-1:0] pin_ts
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_first;
		tx_valid && tx_ready && tx_sop;
	endsequence
	sequence s_last;
		tx_valid && tx_ready && tx_eop;
	endsequence
	AST_TS_STEP: assert property (
		!$past(rst) && !$past(ts_load) && !$past(ts_adj) |-> ts_now == $past(ts_now) + 48'hA)
		else $error("time counter step wrong");
	AST_TS_LOAD: assert property ($past(ts_load) && !$past(rst) |->
		ts_now == $past(ts_load_val)) else $error("time counter load wrong");
	AST_ING_TS: assert property (rx_valid && rx_sop |=>
		ing_ts_valid && ing_ts == $past(ts_now)) else $error("ingress stamp wrong");
	AST_TRAP: assert property (host_trap == (ing_ptp && $past(trap_en)))
		else $error("host trap wrong");
	AST_RESP_START: assert property ($rose(tx_valid) |-> tx_sop && $past(fwd_block))
		else $error("response start without request");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) &&
		$stable(tx_sop) && $stable(tx_eop) && $stable(tx_port)) else $error("byte not held");
	AST_RESP_LEN: assert property (s_first |-> ##[1:300] s_last)
		else $error("response never ends");
	AST_RESP_END: assert property (s_last |=> !tx_valid)
		else $error("valid after last byte");
	AST_PIN_EVT: assert property ($rose(time_sync_pins[0]) |=>
		pin_evt[0] && pin_ts[47:0] == $past(ts_now)) else $error("pin stamp wrong");
endmodule // pdr_checker

bind pdr_responder pdr_checker i_chk (.sys_clk(sys_clk), .rst(rst), .trap_en(trap_en),
	.ts_load(ts_load), .ts_adj(ts_adj), .ts_load_val(ts_load_val), .ts_now(ts_now),
	.rx_valid(rx_valid), .rx_sop(rx_sop), .ing_ts_valid(ing_ts_valid), .ing_ts(ing_ts),
	.ing_ptp(ing_ptp), .host_trap(host_trap), .fwd_block(fwd_block), .tx_ready(tx_ready),
	.tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_data(tx_data),
	.tx_port(tx_port), .time_sync_pins(time_sync_pins), .pin_evt(pin_evt), .pin_ts(pin_ts));

/* File: test/pdr_peer.sv */
// Peer switch model: sends delay requests, sinks responses
`timescale 1ns/1ps
module pdr_peer (
	// Clock
	input wire sys_clk,
	// Requests toward the responder
	output logic rx_valid,
	output logic rx_sop,
	output logic rx_eop,
	output logic [7:0] rx_data,
	output logic [1:0] rx_port,
	// Responses from the responder
	input wire tx_valid,
	input wire tx_sop,
	input wire tx_eop,
	input wire [7:0] tx_data,
	input wire [1:0] tx_port,
	output logic tx_ready
);
	logic [7:0] resp [0:127];
	logic [1:0] resp_port;
	logic stall = 1'b0;
	int n_resp = 0;
	int n_rx = 0;
	initial begin
		rx_valid = 1'b0;
		rx_sop = 1'b0;
		rx_eop = 1'b0;
		rx_data = 8'h00;
		rx_port = 2'h0;
		tx_ready = 1'b0;
	end
	// Both tags use 8100, zero VLAN id
	function logic [7:0] fbyte(input int i, input int t);
		int p;
		p = i - 12 - 4 * t;
		if (i < 12)
			return 8'h01;
		if (p < 0)
			return ((i - 12) % 4 == 0) ? 8'h81 : 8'h00;
		case (p)
			0: return 8'h88;
			1: return 8'hF7;
			2, 3: return 8'h02;
			5: return 8'h36;
			default: return (p >= 22 && p < 32) ? 8'h11 : 8'h00;
		endcase
	endfunction
	// FCS left zero: the responder rebuilds its own
	task send(input int t, input logic [1:0] port);
		int n;
		n = 72 + 4 * t;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			rx_valid <= 1'b1;
			rx_sop <= (i == 0);
			rx_eop <= (i == n - 1);
			rx_data <= fbyte(i, t);
			rx_port <= port;
		end
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		rx_eop <= 1'b0;
		rx_data <= ~rx_data;
	endtask
	// Stall toggles ready so held bytes get exercised
	always @(posedge sys_clk) begin
		tx_ready <= stall ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			resp[tx_sop ? 0 : n_rx] <= tx_data;
			n_rx <= tx_sop ? 1 : n_rx + 1;
			resp_port <= tx_port;
			if (tx_eop)
				n_resp <= n_resp + 1;
		end
	end
endmodule // pdr_peer

/* File: test/tb_top.sv */
// Self-checking bench for the peer-delay responder
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, one_step = 1'b1, p2p_mode = 1'b1, trap_en = 1'b0;
	logic ts_load = 1'b0, ts_adj = 1'b0, eg_sop = 1'b0, eg_ptp = 1'b0, tx_sop, req_drop;
	logic [31:0] ts_adj_delta = 32'h0;
	logic [47:0] t1, t4;
	logic [191:0] efifo_ts;
	logic [143:0] pin_ts;
	logic [3:0] efifo_full;
	logic [1:0] eg_port = 2'h0, rx_port, tx_port;
	logic [3:0] stack_mask = 4'h0, efifo_pop = 4'h0, efifo_empty;
	logic [2:0] pins = 3'h0, pin_evt;
	logic [47:0] ts_load_val = 48'h0, ts_now;
	logic rx_valid, rx_sop, rx_eop, tx_ready, tx_valid, tx_eop, host_trap, fwd_block;
	logic [7:0] rx_data, tx_data;
	int error_cnt = 0, n_checks = 0, cyc = 0, fwd_cnt = 0, trap_cnt = 0, drop_cnt = 0;
	always #5 sys_clk = ~sys_clk;
	pdr_peer i_peer (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_eop(rx_eop),
		.rx_data(rx_data), .rx_port(rx_port), .tx_valid(tx_valid), .tx_sop(tx_sop),
		.tx_eop(tx_eop), .tx_data(tx_data), .tx_port(tx_port), .tx_ready(tx_ready));
	pdr_responder i_dut (.sys_clk(sys_clk), .rst(rst), .one_step(one_step), .p2p_mode(p2p_mode),
		.trap_en(trap_en), .stack_mask(stack_mask), .ts_load(ts_load), .ts_load_val(ts_load_val),
		.ts_adj(ts_adj), .ts_adj_delta(ts_adj_delta), .ts_now(ts_now), .rx_valid(rx_valid),
		.rx_sop(rx_sop), .rx_eop(rx_eop), .rx_data(rx_data), .rx_port(rx_port),
		.ing_ts_valid(), .ing_ts(), .ing_ptp(), .host_trap(host_trap), .fwd_block(fwd_block),
		.req_drop(req_drop), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_sop(tx_sop),
		.tx_eop(tx_eop), .tx_data(tx_data), .tx_port(tx_port), .eg_sop(eg_sop),
		.eg_ptp(eg_ptp), .eg_port(eg_port), .efifo_pop(efifo_pop), .efifo_ts(efifo_ts),
		.efifo_empty(efifo_empty), .efifo_full(efifo_full), .time_sync_pins(pins),
		.pin_evt(pin_evt), .pin_ts(pin_ts));
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Ceiling well above the few thousand cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (fwd_block)
			fwd_cnt <= fwd_cnt + 1;
		if (host_trap)
			trap_cnt <= trap_cnt + 1;
		if (req_drop)
			drop_cnt <= drop_cnt + 1;
		if (rx_valid && rx_sop)
			t1 <= ts_now;
		if (tx_valid && tx_ready && tx_eop)
			t4 <= ts_now;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict;
		end
	end
	task wait_resp(input int n0);
		for (int k = 0; k < 400 && i_peer.n_resp == n0; k++)
			@(negedge sys_clk);
	endtask
	task drain;
		repeat (9) begin
			@(posedge sys_clk);
			efifo_pop <= 4'hF;
			@(posedge sys_clk);
			efifo_pop <= 4'h0;
		end
	endtask
	task t_time;
		@(posedge sys_clk);
		ts_load <= 1'b1;
		ts_load_val <= 48'h000010000000;
		@(posedge sys_clk);
		ts_load <= 1'b0;
		@(negedge sys_clk);
		chk(ts_now, 48'h000010000000);
		@(negedge sys_clk);
		chk(ts_now, 48'h00001000000A);
		@(posedge sys_clk);
		ts_adj <= 1'b1;
		ts_adj_delta <= 32'hFFFFFFFC;
		@(posedge sys_clk);
		ts_adj <= 1'b0;
		@(negedge sys_clk);
		chk(ts_now, 48'h00001000001A);
		$display("test time done");
	endtask
	task t_resp(input int t, input logic [1:0] port, input logic step);
		int o, n, f0, r0, q0;
		logic [63:0] corr;
		logic [79:0] rrts;
		o = 14 + 4 * t;
		n = 72 + 4 * t;
		@(posedge sys_clk);
		one_step <= step;
		trap_en <= step;
		f0 = fwd_cnt;
		r0 = trap_cnt;
		q0 = i_peer.n_resp;
		i_peer.stall = t[0];
		i_peer.send(t, port);
		wait_resp(q0);
		chk(i_peer.n_resp - q0, 1);
		for (int k = 0; k < 8; k++)
			corr = {corr[55:0], i_peer.resp[o + 8 + k]};
		for (int k = 0; k < 10; k++)
			rrts = {rrts[71:0], i_peer.resp[o + 34 + k]};
		chk(i_peer.n_rx, n);
		chk(i_peer.resp_port, port);
		chk(i_peer.resp[o][3:0], 4'h3);
		chk(i_peer.resp[o + 44], 8'h11);
		chk(|rrts, 1'b0);
		chk(corr, step ? 64'((n - 1) * 10) << 16 : 64'h0);
		if (step)
			chk(t4 - t1 > corr[63:16], 1'b1);
		chk(fwd_cnt - f0, 1);
		chk(trap_cnt - r0, step);
		chk(efifo_empty[port], step);
		drain;
		$display("test resp done");
	endtask
	// Second request lands while the first response is still going out
	task t_busy;
		int q0, d0;
		@(posedge sys_clk);
		one_step <= 1'b1;
		q0 = i_peer.n_resp;
		d0 = drop_cnt;
		i_peer.stall = 1'b1;
		i_peer.send(0, 2'h1);
		i_peer.send(2, 2'h1);
		wait_resp(q0);
		chk(i_peer.n_rx, 72);
		chk({i_peer.resp[12], i_peer.resp[13]}, 16'h88F7);
		chk(i_peer.resp_port, 2'h1);
		wait_resp(q0 + 1);
		chk(i_peer.n_resp - q0, 1);
		chk(drop_cnt - d0, 1);
		$display("test busy done");
	endtask
	task t_refuse;
		int q0;
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk);
			stack_mask <= m ? 4'h0 : 4'h8;
			p2p_mode <= m ? 1'b0 : 1'b1;
			q0 = i_peer.n_resp;
			i_peer.send(1, 2'h3);
			wait_resp(q0);
			chk(i_peer.n_resp - q0, 0);
		end
		p2p_mode <= 1'b1;
		$display("test refuse done");
	endtask
	task t_egress;
		logic [47:0] t_eg;
		@(posedge sys_clk);
		one_step <= 1'b0;
		eg_sop <= 1'b1;
		eg_ptp <= 1'b1;
		eg_port <= 2'h2;
		@(negedge sys_clk);
		t_eg = ts_now;
		// Nine pushes into a depth of eight: the last is dropped
		repeat (9) @(posedge sys_clk);
		eg_sop <= 1'b0;
		@(negedge sys_clk);
		chk(efifo_empty, 4'hB);
		chk(efifo_full, 4'h4);
		chk(efifo_ts[143:96], t_eg);
		drain;
		chk(efifo_empty, 4'hF);
		$display("test egress done");
	endtask
	task t_pins;
		logic [47:0] t_p;
		@(posedge sys_clk);
		pins <= 3'h7;
		@(negedge sys_clk);
		t_p = ts_now;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk(pin_evt, 3'h7);
		for (int k = 0; k < 3; k++)
			chk(pin_ts[k*48 +: 48], t_p);
		pins <= 3'h0;
		$display("test pins done");
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		t_time;
		for (int s = 0; s < 2; s++)
			for (int t = 0; t < 3; t++)
				t_resp(t, 2'(t + s), s == 0);
		t_busy;
		t_refuse;
		t_egress;
		t_pins;
		print_verdict;
	end
endmodule // tb_top
